// ===== hw/idc_pkg.sv
// Constants shared by the instruction field decoder
package idc_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] IDC_CTRL_OFS = 8'h00;
  localparam logic [7:0] IDC_STAT_OFS = 8'h04;
  localparam logic [7:0] IDC_CNT_OFS = 8'h08;
  localparam logic [31:0] IDC_CTRL_RST = 32'h00000000;
  localparam int CB_PE = 0;
  localparam int CB_VM = 1;
  localparam int CB_CPL = 2;
  localparam int CB_IO_PRIVILEGE_LEVEL = 4;
  localparam int CB_D32 = 6;
  localparam int CB_A32 = 7;
  localparam int CB_IF = 8;
  // ****************************************
  // Opcodes and group selectors
  // ****************************************
  localparam logic [7:0] OP_TWO = 8'h0F;
  localparam logic [2:0] G6_LLDT = 3'h2;
  localparam logic [2:0] G6_LTR = 3'h3;
  localparam logic [2:0] G6_STR = 3'h1;
  localparam logic [2:0] G6_VERIFY_READABLE = 3'h4;
  localparam logic [2:0] G6_VERIFY_WRITABLE = 3'h5;
  localparam logic [2:0] G7_LGDT = 3'h2;
  localparam logic [2:0] G7_LIDT = 3'h3;
  localparam logic [2:0] G7_STORE_MACHINE_STATUS = 3'h4;
  localparam logic [2:0] G7_LMSW = 3'h6;
  // ****************************************
  // Fault vectors, limits, clock counts
  // ****************************************
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NP = 8'h0B;
  localparam logic [7:0] VEC_SS = 8'h0C;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [32:0] REAL_LIMIT = 33'h00000FFFF;
  localparam logic [5:0] MUL_MIN = 6'h03;
  localparam logic [5:0] MUL_RR = 6'h09;
  localparam logic [5:0] MUL_MR = 6'h0C;
  localparam logic [5:0] MUL_RI = 6'h0A;
  localparam logic [5:0] MUL_MI = 6'h0B;
  localparam logic [5:0] CLK_STR = 6'h02;
  localparam logic [5:0] CLK_STORE_MACHINE_STATUS = 6'h02;
  localparam logic [5:0] CLK_VERIFY_READABLE_R = 6'h0A;
  localparam logic [5:0] CLK_VERIFY_READABLE_M = 6'h0B;
  localparam logic [5:0] CLK_VERIFY_WRITABLE_R = 6'h0F;
  localparam logic [5:0] CLK_VERIFY_WRITABLE_M = 6'h10;
endpackage : idc_pkg

// ===== hw/idc_decoder.sv
// Instruction field decoder with mode, fault and bus lock checks
`timescale 1ns/10ps
module idc_decoder (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic insn_valid,
  output logic insn_ready,
  input wire logic [127:0] insn_bytes,
  input wire logic [31:0] mul_operand,
  input wire logic dec_ready,
  output logic dec_valid,
  output logic [7:0] dec_opcode,
  output logic dec_two_byte,
  output logic [3:0] dec_len,
  output logic dec_has_modrm,
  output logic dec_has_sib,
  output logic [1:0] dec_mod,
  output logic [2:0] dec_reg,
  output logic [2:0] dec_rm,
  output logic [1:0] dec_scale,
  output logic [2:0] dec_index,
  output logic [2:0] dec_base,
  output logic [31:0] dec_disp,
  output logic [31:0] dec_imm,
  output logic dec_w,
  output logic dec_d,
  output logic dec_s,
  output logic [1:0] dec_four_segment_selector,
  output logic [2:0] dec_six_segment_selector,
  output logic [3:0] dec_cond,
  output logic [2:0] dec_op_bytes,
  output logic [5:0] dec_clocks,
  output logic dec_fault,
  output logic [7:0] dec_vector,
  input wire logic chk_valid,
  input wire logic chk_mem,
  input wire logic [31:0] chk_offset,
  input wire logic [2:0] chk_bytes,
  input wire logic chk_stack,
  input wire logic chk_limit_fail,
  input wire logic chk_rights_fail,
  input wire logic chk_start_fail,
  input wire logic chk_seg_load,
  input wire logic chk_priv_ok,
  input wire logic chk_present,
  input wire logic chk_far_fail,
  output logic chk_done,
  output logic chk_fault,
  output logic [7:0] chk_vector,
  output logic zf_clear,
  input wire logic flag_restore_valid,
  input wire logic restore_if,
  input wire logic [1:0] restore_io_privilege_level,
  input wire logic restore_vm,
  input wire logic msw_load_valid,
  input wire logic msw_pe,
  input wire logic cr0_write_valid,
  input wire logic cr0_pe,
  input wire logic desc_access,
  input wire logic instr_done,
  output logic bus_lock
);
  import idc_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] byte_at(input logic [127:0] b, input logic [4:0] i);
    logic [127:0] t;
    t = b >> {i, 3'b000};
    return t[7:0];
  endfunction : byte_at

  function automatic logic [31:0] word_at(input logic [127:0] b, input logic [4:0] i);
    logic [127:0] t;
    t = b >> {i, 3'b000};
    return t[31:0];
  endfunction : word_at

  function automatic logic [31:0] sext(input logic [31:0] v, input logic [2:0] n);
    if (n == 3'd1) return {{24{v[7]}}, v[7:0]};
    else if (n == 3'd2) return {{16{v[15]}}, v[15:0]};
    else if (n == 3'd4) return v;
    else return 32'h00000000;
  endfunction : sext

  // Ceiling of log2 of the magnitude
  function automatic logic [5:0] clog_mag(input logic [31:0] m);
    logic [32:0] a;
    logic [5:0] r;
    a = m[31] ? {1'b0, ~m} + 33'h1 : {1'b0, m};
    r = 6'h00;
    for (int k = 0; k < 33; k++) begin
      if ((33'h1 << k) < a) r = 6'(k + 1);
    end
    return r;
  endfunction : clog_mag

  function automatic logic has_modrm(input logic two, input logic [7:0] o);
    if (two) begin
      case (o) inside
        [8'h00:8'h03], [8'h20:8'h23], [8'h90:8'h9F], 8'hA3, 8'hA4, 8'hA5, 8'hAB,
        8'hAC, 8'hAD, 8'hAF, [8'hB2:8'hB7], [8'hBA:8'hBF]: return 1'b1;
        default: return 1'b0;
      endcase
    end
    if (o < 8'h40) return ~o[2];
    case (o) inside
      8'h62, 8'h63, 8'h69, 8'h6B, [8'h80:8'h8F], 8'hC0, 8'hC1, [8'hC4:8'hC7],
      [8'hD0:8'hD3], [8'hD8:8'hDF], 8'hF6, 8'hF7, 8'hFE, 8'hFF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : has_modrm

  function automatic logic [2:0] imm_size(input logic two, input logic [7:0] o,
                                          input logic [2:0] r, input logic [2:0] v);
    if (two) begin
      case (o) inside
        [8'h80:8'h8F]: return v;
        8'hA4, 8'hAC, 8'hBA: return 3'd1;
        default: return 3'd0;
      endcase
    end
    if (o < 8'h40 && o[2:1] == 2'b10) return o[0] ? v : 3'd1;
    case (o) inside
      8'h68, 8'h69, 8'h81, 8'hC7, 8'hE8, 8'hE9, 8'hA9, [8'hB8:8'hBF]: return v;
      8'h6A, 8'h6B, 8'h80, 8'h83, 8'hC0, 8'hC1, 8'hC6, 8'hCD, 8'hEB, 8'hA8,
      [8'hB0:8'hB7], [8'hE4:8'hE7], [8'h70:8'h7F]: return 3'd1;
      8'hC2, 8'hCA: return 3'd2;
      8'hF6: return (r == 3'd0) ? 3'd1 : 3'd0;
      8'hF7: return (r == 3'd0) ? v : 3'd0;
      default: return 3'd0;
    endcase
  endfunction : imm_size

  // ****************************************
  // Control state
  // ****************************************
  logic [31:0] ctrl_q;
  logic [31:0] cnt_q;
  logic [7:0] last_vec_q;
  logic pe, vm, d32, a32;
  logic [1:0] current_privilege_level, io_privilege_level;
  assign pe = ctrl_q[CB_PE];
  assign vm = ctrl_q[CB_VM];
  assign current_privilege_level = ctrl_q[CB_CPL +: 2];
  assign io_privilege_level = ctrl_q[CB_IO_PRIVILEGE_LEVEL +: 2];
  assign d32 = ctrl_q[CB_D32];
  assign a32 = ctrl_q[CB_A32];

  // ****************************************
  // Bus slave, zero wait states
  // ****************************************
  logic wr_q;
  logic [7:0] adr_q;
  logic aphase;
  assign aphase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q <= aphase & hwrite;
      if (aphase) adr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (aphase && !hwrite) begin
      case (haddr[7:0])
        IDC_CTRL_OFS: hrdata <= ctrl_q;
        IDC_STAT_OFS: hrdata <= {24'h000000, last_vec_q};
        IDC_CNT_OFS: hrdata <= cnt_q;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Hardware updates land after the software write so they win
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= IDC_CTRL_RST;
    end else begin
      if (wr_q && adr_q == IDC_CTRL_OFS) ctrl_q <= {23'h000000, hwdata[8:0]};
      if (flag_restore_valid) begin
        if (current_privilege_level <= io_privilege_level) ctrl_q[CB_IF] <= restore_if;
        if (current_privilege_level == 2'd0) begin
          ctrl_q[CB_IO_PRIVILEGE_LEVEL +: 2] <= restore_io_privilege_level;
          ctrl_q[CB_VM] <= restore_vm;
        end
      end
      if (msw_load_valid) ctrl_q[CB_PE] <= pe | msw_pe;
      if (cr0_write_valid) ctrl_q[CB_PE] <= cr0_pe;
    end
  end

  // ****************************************
  // Field parse
  // ****************************************
  logic two, mrm_en, sib_en, mem;
  logic [7:0] opc, mrm, sib;
  logic [4:0] p_op, p_sib, p_disp, p_imm;
  logic [2:0] dsz, isz, vsz;
  logic [4:0] len;

  always_comb begin
    two = byte_at(insn_bytes, 5'd0) == OP_TWO;
    p_op = two ? 5'd2 : 5'd1;
    opc = byte_at(insn_bytes, p_op - 5'd1);
    mrm_en = has_modrm(two, opc);
    mrm = mrm_en ? byte_at(insn_bytes, p_op) : 8'h00;
    p_sib = p_op + {4'h0, mrm_en};
    mem = mrm_en & (mrm[7:6] != 2'b11);
    sib_en = mem & a32 & (mrm[2:0] == 3'b100);
    sib = sib_en ? byte_at(insn_bytes, p_sib) : 8'h00;
    p_disp = p_sib + {4'h0, sib_en};
    if (!mem) dsz = 3'd0;
    else if (mrm[7:6] == 2'b01) dsz = 3'd1;
    else if (a32) dsz = (mrm[7:6] == 2'b10 || (!sib_en && mrm[2:0] == 3'b101) ||
                         (sib_en && sib[2:0] == 3'b101)) ? 3'd4 : 3'd0;
    else dsz = (mrm[7:6] == 2'b10 || mrm[2:0] == 3'b110) ? 3'd2 : 3'd0;
    vsz = d32 ? 3'd4 : 3'd2;
    isz = imm_size(two, opc, mrm[5:3], vsz);
    p_imm = p_disp + {2'b00, dsz};
    len = p_imm + {2'b00, isz};
  end

  // ****************************************
  // Instruction classes and decode faults
  // ****************************************
  logic g6, g7, prot_only, privd, io_sens, sel_chk, desc_lk, xchg_lk, coprocessor_escape;
  logic [5:0] clk_d, mbase;
  logic fault_d;
  logic [7:0] vec_d;
  logic [5:0] mlog;

  always_comb begin
    g6 = two & (opc == 8'h00);
    g7 = two & (opc == 8'h01);
    prot_only = g6 | (two & (opc == 8'h02 || opc == 8'h03)) | (!two & opc == 8'h63);
    privd = (g7 & (mrm[5:3] == G7_LGDT || mrm[5:3] == G7_LIDT || mrm[5:3] == G7_LMSW))
          | (g6 & (mrm[5:3] == G6_LLDT || mrm[5:3] == G6_LTR));
    io_sens = !two & (opc inside {[8'hE4:8'hE7], [8'hEC:8'hEF], 8'hFA, 8'hFB});
    sel_chk = (g6 & (mrm[5:3] == G6_VERIFY_READABLE || mrm[5:3] == G6_VERIFY_WRITABLE))
            | (two & (opc == 8'h02 || opc == 8'h03));
    desc_lk = sel_chk | (g6 & (mrm[5:3] == G6_LLDT || mrm[5:3] == G6_LTR));
    xchg_lk = !two & (opc == 8'h86 || opc == 8'h87) & mem;
    coprocessor_escape = !two & (opc inside {[8'hD8:8'hDF]});
    mlog = clog_mag(mul_operand);
    if (mlog < MUL_MIN) mlog = MUL_MIN;
    mbase = 6'h00;
    if (!two && (opc == 8'hF6 || opc == 8'hF7) && mrm[5:4] == 2'b10)
      mbase = mem ? MUL_MR : MUL_RR;
    else if (!two && (opc == 8'h69 || opc == 8'h6B)) mbase = mem ? MUL_MI : MUL_RI;
    else if (two && opc == 8'hAF) mbase = mem ? MUL_MR : MUL_RR;
    if (mbase != 6'h00) clk_d = mlog + mbase;
    else if (g6 && mrm[5:3] == G6_STR) clk_d = CLK_STR;
    else if (g6 && mrm[5:3] == G6_VERIFY_READABLE) clk_d = mem ? CLK_VERIFY_READABLE_M : CLK_VERIFY_READABLE_R;
    else if (g6 && mrm[5:3] == G6_VERIFY_WRITABLE) clk_d = mem ? CLK_VERIFY_WRITABLE_M : CLK_VERIFY_WRITABLE_R;
    else if (g7 && mrm[5:3] == G7_STORE_MACHINE_STATUS) clk_d = CLK_STORE_MACHINE_STATUS;
    else clk_d = 6'h00;
    fault_d = 1'b1;
    vec_d = 8'h00;
    if (prot_only && !pe) vec_d = VEC_UD;
    else if (pe && privd && current_privilege_level != 2'd0) vec_d = VEC_GP;
    else if (pe && io_sens && current_privilege_level > io_privilege_level) vec_d = VEC_GP;
    else fault_d = 1'b0;
  end

  // ****************************************
  // Decode output stage
  // ****************************************
  logic accept;
  logic sel_chk_q, desc_lk_q, xchg_lk_q, esc_q;
  assign insn_ready = dec_ready | ~dec_valid;
  assign accept = insn_valid & insn_ready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dec_valid <= 1'b0;
    else if (accept) dec_valid <= 1'b1;
    else if (dec_ready) dec_valid <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {dec_opcode, dec_two_byte, dec_len, dec_has_modrm, dec_has_sib} <= '0;
      {dec_mod, dec_reg, dec_rm, dec_scale, dec_index, dec_base} <= '0;
      {dec_disp, dec_imm, dec_w, dec_d, dec_s, dec_cond, dec_op_bytes} <= '0;
      {dec_four_segment_selector, dec_six_segment_selector} <= '0;
      {dec_clocks, dec_fault, dec_vector} <= '0;
      {sel_chk_q, desc_lk_q, xchg_lk_q, esc_q} <= '0;
    end else if (accept) begin
      dec_opcode <= opc;
      dec_two_byte <= two;
      dec_len <= len[3:0];
      dec_has_modrm <= mrm_en;
      dec_has_sib <= sib_en;
      dec_mod <= mrm[7:6];
      dec_reg <= mrm[5:3];
      dec_rm <= mrm[2:0];
      dec_scale <= sib[7:6];
      dec_index <= sib[5:3];
      dec_base <= sib[2:0];
      dec_disp <= sext(word_at(insn_bytes, p_disp), dsz);
      dec_imm <= sext(word_at(insn_bytes, p_imm), isz);
      dec_w <= opc[0];
      dec_d <= opc[1];
      dec_s <= opc[1];
      dec_cond <= opc[3:0];
      dec_four_segment_selector <= opc[4:3];
      dec_six_segment_selector <= mrm[5:3];
      dec_op_bytes <= opc[0] ? vsz : 3'd1;
      dec_clocks <= clk_d;
      dec_fault <= fault_d;
      dec_vector <= vec_d;
      sel_chk_q <= sel_chk;
      desc_lk_q <= desc_lk;
      xchg_lk_q <= xchg_lk;
      esc_q <= coprocessor_escape;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= 32'h00000000;
    else if (accept) cnt_q <= cnt_q + 32'h1;
  end

  // Lock held to instruction end for exchange with a memory operand; tracks each descriptor access of selector checks, LLDT and LTR
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) bus_lock <= 1'b0;
    else if (accept) bus_lock <= xchg_lk;
    else bus_lock <= (xchg_lk_q & bus_lock & ~instr_done) | (desc_lk_q & desc_access);
  end

  // ****************************************
  // Operand checks
  // ****************************************
  logic [32:0] last_b;
  logic c_f, c_zf;
  logic [7:0] c_v;

  always_comb begin
    last_b = {1'b0, chk_offset} + {30'h0, chk_bytes} - 33'h1;
    c_f = 1'b1;
    c_zf = 1'b0;
    c_v = 8'h00;
    if (!pe) begin
      if (chk_mem && chk_stack && esc_q && {1'b0, chk_offset} > REAL_LIMIT) c_v = VEC_SS;
      else if (chk_mem && chk_stack && !esc_q && last_b > REAL_LIMIT) c_v = VEC_SS;
      else if (chk_mem && !chk_stack && last_b > REAL_LIMIT) c_v = VEC_GP;
      else c_f = 1'b0;
    end else if (chk_far_fail) c_v = VEC_GP;
    else if (chk_seg_load && !chk_priv_ok) begin
      if (sel_chk_q) begin
        c_f = 1'b0;
        c_zf = 1'b1;
      end else c_v = VEC_GP;
    end else if (chk_seg_load && !chk_present) c_v = chk_stack ? VEC_SS : VEC_NP;
    else if (chk_mem && esc_q && (chk_limit_fail || chk_rights_fail || chk_start_fail))
      c_v = (chk_stack && chk_start_fail) ? VEC_SS : VEC_GP;
    else if (chk_mem && (chk_limit_fail || chk_rights_fail))
      c_v = (chk_stack && chk_limit_fail) ? VEC_SS : VEC_GP;
    else c_f = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {chk_done, chk_fault, chk_vector, zf_clear} <= '0;
    end else begin
      chk_done <= chk_valid;
      chk_fault <= chk_valid & c_f;
      chk_vector <= chk_valid ? c_v : 8'h00;
      zf_clear <= chk_valid & c_zf;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) last_vec_q <= 8'h00;
    else if (chk_valid && c_f) last_vec_q <= c_v;
    else if (accept && fault_d) last_vec_q <= vec_d;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ud_real;
    accept && prot_only && !pe |=> dec_fault && dec_vector == VEC_UD;
  endproperty
  a_ud_real: assert property (p_ud_real) else $error("missing vector 6");
  property p_str_clk;
    accept && g6 && mrm[5:3] == G6_STR |=> dec_clocks == CLK_STR;
  endproperty
  a_str_clk: assert property (p_str_clk) else $error("bad store selector clocks");
  property p_verify_writable_clk;
    accept && g6 && mrm[5:3] == G6_VERIFY_WRITABLE && mem |=> dec_clocks == CLK_VERIFY_WRITABLE_M;
  endproperty
  a_verify_writable_clk: assert property (p_verify_writable_clk) else $error("bad verify clocks");
  property p_mul_zero;
    accept && mbase != 6'h00 && mul_operand == 32'h0 |=> dec_clocks == $past(mbase) + MUL_MIN;
  endproperty
  a_mul_zero: assert property (p_mul_zero) else $error("bad zero multiply");
  property p_real_gp;
    chk_valid && !pe && chk_mem && !chk_stack && last_b > REAL_LIMIT
      |=> chk_fault && chk_vector == VEC_GP;
  endproperty
  a_real_gp: assert property (p_real_gp) else $error("missing real fault 13");
  property p_real_ss;
    chk_valid && !pe && chk_mem && chk_stack && !esc_q && last_b > REAL_LIMIT
      |=> chk_vector == VEC_SS;
  endproperty
  a_real_ss: assert property (p_real_ss) else $error("missing stack fault");
  property p_priv;
    accept && pe && privd && current_privilege_level != 2'd0 && !prot_only |=> dec_vector == VEC_GP;
  endproperty
  a_priv: assert property (p_priv) else $error("missing privilege fault");
  property p_pe_keep;
    pe && msw_load_valid && !cr0_write_valid |=> pe;
  endproperty
  a_pe_keep: assert property (p_pe_keep) else $error("status load cleared pe");
  property p_zf;
    chk_valid && pe && !chk_far_fail && chk_seg_load && !chk_priv_ok && sel_chk_q
      |=> zf_clear && !chk_fault;
  endproperty
  a_zf: assert property (p_zf) else $error("selector check faulted");
  property p_xchg_lock;
    accept && xchg_lk |=> bus_lock;
  endproperty
  a_xchg_lock: assert property (p_xchg_lock) else $error("no implicit lock");
  property p_len;
    accept |=> dec_valid && dec_len >= 4'(1 + dec_two_byte);
  endproperty
  a_len: assert property (p_len) else $error("bad length");

  c_mul: cover property (accept && mbase != 6'h00 && mul_operand[31]);
  c_sib: cover property (accept && sib_en && dsz == 3'd4 && isz != 3'd0);
  c_np: cover property (chk_valid && pe && chk_seg_load && chk_priv_ok && !chk_present);
endmodule : idc_decoder

// ===== verif/idc_exec_model.sv
// Execution stage stand-in that takes decoded words
`timescale 1ns/10ps
module idc_exec_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stall,
  output logic dec_ready
);
  // ****
  // Consumer
  // ****
  // Random stalls force the decoder to hold its outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_ready <= 1'b0;
    end else begin
      dec_ready <= ~stall;
    end
  end
endmodule : idc_exec_model

// ===== verif/idc_decoder_bench.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/10ps
module idc_decoder_bench;
  import idc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, insn_valid, insn_ready;
  logic dec_ready, dec_valid, dec_two_byte, dec_has_modrm, dec_has_sib, dec_w, dec_d, dec_s;
  logic dec_fault, chk_valid, chk_mem, chk_stack, chk_limit_fail, chk_rights_fail;
  logic chk_start_fail, chk_seg_load, chk_priv_ok, chk_present, chk_far_fail, chk_done;
  logic chk_fault, zf_clear, flag_restore_valid, restore_if, restore_vm, msw_load_valid;
  logic msw_pe, cr0_write_valid, cr0_pe, desc_access, instr_done, bus_lock, stall;
  logic [31:0] haddr, hwdata, hrdata, mul_operand, chk_offset, dec_disp, dec_imm, rd, m;
  logic [1:0] htrans, dec_mod, dec_scale, dec_four_segment_selector, restore_io_privilege_level;
  logic [2:0] hsize, dec_reg, dec_rm, dec_index, dec_base, dec_six_segment_selector;
  logic [2:0] dec_op_bytes, chk_bytes;
  logic [127:0] insn_bytes;
  logic [7:0] dec_opcode, dec_vector, chk_vector, r;
  logic [3:0] dec_len, dec_cond, len;
  logic [5:0] dec_clocks;
  logic [15:0] d;
  int fails, tests_run, seed, n;
  idc_decoder dut_u (.*);
  idc_exec_model exec_u (.*);
  assign hready = hreadyout;
  always #25 hclk = ~hclk;
  always @(posedge hclk) stall <= 1'($random(seed));
  // ****
  // Tasks
  // ****
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic stop_test();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    rd = hrdata;
    hsel <= 1'b0;
    if (n >= 50) fails++;
  endtask : bus
  task automatic dec(input logic [127:0] b, input logic [7:0] ev, input logic [5:0] ck);
    n = 0;
    @(posedge hclk);
    insn_bytes <= b;
    mul_operand <= m;
    insn_valid <= 1'b1;
    do @(negedge hclk); while (insn_ready !== 1'b1 && ++n < 50);
    @(posedge hclk);
    insn_valid <= 1'b0;
    @(negedge hclk);
    if (n >= 50) fails++;
    cmp(dec_valid, 1'b1);
    cmp({dec_fault, dec_vector}, {ev != 8'h00, ev});
    if (ck !== 6'h3F) cmp(dec_clocks, ck);
  endtask : dec
  task automatic chk(input logic [8:0] f, input logic [31:0] o, input logic [7:0] ev, input logic z);
    @(posedge hclk);
    {chk_mem, chk_stack, chk_limit_fail, chk_rights_fail, chk_start_fail} <= f[8:4];
    {chk_seg_load, chk_priv_ok, chk_present, chk_far_fail} <= f[3:0];
    chk_offset <= o;
    chk_valid <= 1'b1;
    @(posedge hclk);
    chk_valid <= 1'b0;
    @(negedge hclk);
    cmp({chk_done, chk_fault, chk_vector, zf_clear}, {1'b1, ev != 8'h00, ev, z});
  endtask : chk
  task automatic pls(input logic [2:0] v, input logic [3:0] x, input logic [31:0] e);
    @(posedge hclk);
    {flag_restore_valid, msw_load_valid, cr0_write_valid} <= v;
    {restore_if, restore_io_privilege_level, restore_vm} <= x;
    msw_pe <= x[0];
    cr0_pe <= x[0];
    @(posedge hclk);
    {flag_restore_valid, msw_load_valid, cr0_write_valid} <= 3'h0;
    bus(1'b0, IDC_CTRL_OFS, 32'h0);
    cmp(rd, e);
  endtask : pls
  // Multiplier cost: smallest k with 2**k >= |m|, floor of 3, register base
  function automatic logic [5:0] mclk(input logic [31:0] v);
    logic [32:0] a;
    int k;
    a = {1'b0, v[31] ? -v : v};
    k = 0;
    while (k < 32 && (33'h1 << k) < a) k++;
    return (k < 3) ? MUL_MIN + MUL_RR : 6'(k) + MUL_RR;
  endfunction : mclk
  // ****
  // Sequence
  // ****
  initial begin
    seed = 32'h562B99F7;
    {hclk, hresetn, hsel, hwrite, insn_valid, chk_valid, chk_mem, chk_stack, stall} = '0;
    {chk_limit_fail, chk_rights_fail, chk_start_fail, chk_seg_load, chk_priv_ok} = '0;
    {chk_present, chk_far_fail, flag_restore_valid, restore_if, restore_vm} = '0;
    {msw_load_valid, msw_pe, cr0_write_valid, cr0_pe, desc_access, instr_done} = '0;
    {haddr, hwdata, mul_operand, chk_offset, m, htrans, restore_io_privilege_level, insn_bytes} = '0;
    hsize = 3'h2;
    chk_bytes = 3'h4;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, IDC_CTRL_OFS, 32'h0);
    cmp(rd, IDC_CTRL_RST);
    bus(1'b0, 32'h00000010, 32'h0);
    cmp(rd, 32'h0);
    dec(128'hC8000F, VEC_UD, 6'h3F);
    chk(9'h106, 32'h0000FFFE, VEC_GP, 1'b0);
    chk(9'h106, 32'h0000FFFC, 8'h00, 1'b0);
    chk(9'h186, 32'h0000FFFE, VEC_SS, 1'b0);
    bus(1'b1, IDC_CTRL_OFS, 32'h1);
    dec(128'hC8000F, 8'h00, CLK_STR);
    dec(128'h28000F, 8'h00, CLK_VERIFY_WRITABLE_M);
    dec(128'hE0000F, 8'h00, CLK_VERIFY_READABLE_R);
    chk(9'h008, 32'h0, 8'h00, 1'b1);
    chk(9'h007, 32'h0, VEC_GP, 1'b0);
    chk(9'h00C, 32'h0, VEC_NP, 1'b0);
    chk(9'h08C, 32'h0, VEC_SS, 1'b0);
    chk(9'h146, 32'h0, VEC_GP, 1'b0);
    chk(9'h126, 32'h0, VEC_GP, 1'b0);
    chk(9'h1C6, 32'h0, VEC_SS, 1'b0);
    @(posedge hclk);
    desc_access <= 1'b1;
    repeat (2) @(negedge hclk);
    cmp(bus_lock, 1'b1);
    @(posedge hclk);
    desc_access <= 1'b0;
    repeat (2) @(negedge hclk);
    cmp(bus_lock, 1'b0);
    dec(128'h0087, 8'h00, 6'h3F);
    repeat (2) @(negedge hclk);
    cmp(bus_lock, 1'b1);
    @(posedge hclk);
    instr_done <= 1'b1;
    @(posedge hclk);
    instr_done <= 1'b0;
    repeat (2) @(negedge hclk);
    cmp(bus_lock, 1'b0);
    for (int i = 0; i < 24; i++) begin
      m = (i == 0) ? 32'h0 : (i == 1) ? 32'h80000000 : $random(seed) >>> (i % 32);
      dec(128'hC1AF0F, 8'h00, mclk(m));
      r = 8'($random(seed));
      d = 16'($random(seed));
      len = (r[7:6] == 2'h1) ? 4'h3 : (r[7:6] == 2'h2 || r[7:0] ==? 8'b00xxx110) ? 4'h4 : 4'h2;
      dec({96'h0, d, r, 8'h8B}, 8'h00, 6'h3F);
      cmp({dec_len, dec_mod, dec_reg, dec_rm, dec_six_segment_selector}, {len, r, r[5:3]});
      cmp({dec_op_bytes, dec_w, dec_d, dec_cond, dec_four_segment_selector}, 11'h2ED);
      if (len == 4'h3) cmp(dec_disp, {{24{d[7]}}, d[7:0]});
      if (len == 4'h4) cmp(dec_disp, {{16{d[15]}}, d});
    end
    bus(1'b1, IDC_CTRL_OFS, 32'hC1);
    dec(128'h12345678F08D4481, 8'h00, 6'h3F);
    cmp({dec_len, dec_has_sib, dec_scale, dec_index, dec_base}, {4'h8, 1'b1, 8'h8D});
    cmp({dec_two_byte, dec_has_modrm, dec_op_bytes, dec_mod, dec_rm}, 10'h18C);
    cmp(dec_disp, 32'hFFFFFFF0);
    cmp(dec_imm, 32'h12345678);
    bus(1'b1, IDC_CTRL_OFS, 32'h10D);
    dec(128'h10010F, VEC_GP, 6'h3F);
    dec(128'h00E4, VEC_GP, 6'h3F);
    bus(1'b0, IDC_STAT_OFS, 32'h0);
    cmp(rd, {24'h000000, VEC_GP});
    cmp({hreadyout, hresp}, 2'b10);
    pls(3'h4, 4'h7, 32'h10D);
    bus(1'b1, IDC_CTRL_OFS, 32'h1);
    pls(3'h4, 4'hC, 32'h121);
    pls(3'h2, 4'h0, 32'h121);
    pls(3'h1, 4'h0, 32'h120);
    pls(3'h2, 4'h1, 32'h121);
    stop_test();
  end
  initial begin
    #2000000;
    fails++;
    stop_test();
  end
endmodule : idc_decoder_bench
